/* File: rtl/wdlr_link.sv */
// Word data link refresh: four paired areas between position data and host words.
// Assumes host pulses refresh_strobe once per cyclic I/O refresh and the
// program side supplies position words and the stopover copy source data.
`timescale 1ns/1ps
module wdlr_link
    import wdlr_pkg::*;
#(
    parameter int SETTLE_COUNT = SETTLE_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Host side
    input wire logic refresh_strobe,
    input wire logic unit_config_write,
    input wire logic [AREA_COUNT-1:0] config_enable,
    input wire logic host_outputs_off,
    input wire logic [AREA_COUNT*WORD_BITS-1:0] host_in_words,
    output logic [AREA_COUNT*WORD_BITS-1:0] host_out_words,
    // Program side: assign_value_command writes to output words
    input wire logic assign_value_command,
    input wire logic [2:0] write_index,
    input wire logic [POS_BITS-1:0] write_data,
    // Stopover copy
    input wire logic stopover_select_write,
    input wire logic [POS_BITS-1:0] stopover_copy_select,
    input wire logic stopover_output,
    output logic [ADDR_BITS-1:0] copy_src_addr,
    input wire logic [POS_BITS-1:0] copy_src_low,
    input wire logic [POS_BITS-1:0] copy_src_high,
    // Position data from the input areas
    output logic [AREA_COUNT*2*POS_BITS-1:0] input_pos_words,
    output logic copy_armed
);
    ////////////////////////////////////////////////////////////////////
    logic [POS_BITS-1:0] out_pos_q [2*AREA_COUNT];
    logic [POS_BITS-1:0] staged_q [2*AREA_COUNT];
    logic [2*AREA_COUNT-1:0] pending_q;
    logic [AREA_COUNT-1:0] enable_q;
    logic [1:0] zero_left_q [AREA_COUNT];
    logic [31:0] settle_q;
    logic settling_q;
    logic armed_q;
    logic [ADDR_BITS-1:0] src_q;
    logic [AREA_COUNT*WORD_BITS-1:0] host_out_q;
    logic [AREA_COUNT*2*POS_BITS-1:0] in_pos_q;
    logic [AREA_COUNT*WORD_BITS-1:0] conv_word;
    logic [AREA_COUNT*2*POS_BITS-1:0] conv_pos;
    logic [AREA_COUNT-1:0] new_enable;
    logic [1:0] first_left;
    logic sel_arm;
    logic [ADDR_BITS-1:0] sel_addr;
    logic [2*AREA_COUNT-1:0] word_hit;
    logic [2*AREA_COUNT-1:0] pending_d;
    logic quiet_edge;
    logic copy_take;
    logic [AREA_COUNT-1:0] area_refresh;
    logic [AREA_COUNT-1:0] area_blank;
    logic [AREA_COUNT*WORD_BITS-1:0] host_next;

    // One-hot select of the output position word named by an index
    function automatic logic [2*AREA_COUNT-1:0] word_decode(input logic [2:0] idx);
        logic [2*AREA_COUNT-1:0] hot;
        hot = '0;
        hot[idx] = 1'b1;
        return hot;
    endfunction

    assign new_enable = config_enable & ~enable_q;
    // Zero refreshes still owed after the first one; the settling decision is
    // taken at that first refresh, since only then is the elapsed time known
    assign first_left = settling_q ? ZERO_REFRESHES : 2'h0;
    assign word_hit = assign_value_command ? word_decode(write_index) : '0;
    assign pending_d = refresh_strobe ? (pending_q | word_hit) : '0;
    assign quiet_edge = !refresh_strobe;
    assign copy_take = stopover_output && armed_q && quiet_edge;
    assign area_refresh = refresh_strobe ? enable_q : '0;
    assign sel_arm = stopover_copy_select[POS_BITS-1 -: DIGIT_BITS] == SEL_ARM_DIGIT;
    assign sel_addr = stopover_copy_select[ADDR_BITS-1:0];

    for (genvar a = 0; a < AREA_COUNT; a++) begin : g_area
        wdlr_convert u_conv (
            .pos_low(out_pos_q[2*a]),
            .pos_high(out_pos_q[2*a+1]),
            .host_word(host_in_words[a*WORD_BITS +: WORD_BITS]),
            .out_word(conv_word[a*WORD_BITS +: WORD_BITS]),
            .in_pos_low(conv_pos[2*a*POS_BITS +: POS_BITS]),
            .in_pos_high(conv_pos[(2*a+1)*POS_BITS +: POS_BITS])
        );
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            settle_q <= '0;
            settling_q <= 1'b0;
        end else if (unit_config_write) begin
            settle_q <= 32'(SETTLE_COUNT);
            settling_q <= 1'b1;
        end else if (settle_q > 1) begin
            settle_q <= settle_q - 32'd1;
        end else begin
            settle_q <= '0;
            settling_q <= 1'b0;
        end
    end

    // Stopover copy arm and disarm
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            armed_q <= 1'b0;
            src_q <= '0;
        end else if (stopover_select_write) begin
            armed_q <= sel_arm;
            src_q <= sel_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output position words
    // A write that lands on a refresh edge is parked: that refresh must still
    // convert the old word, and the new one goes out on the following refresh
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 2*AREA_COUNT; i++) begin
                staged_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < 2*AREA_COUNT; i++) begin
                if (refresh_strobe && word_hit[i]) begin
                    staged_q[i] <= write_data;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pending_q <= '0;
        end else begin
            pending_q <= pending_d;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 2*AREA_COUNT; i++) begin
                out_pos_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < 2*AREA_COUNT; i++) begin
                if (quiet_edge && word_hit[i]) begin
                    out_pos_q[i] <= write_data;
                end else if (quiet_edge && pending_q[i]) begin
                    out_pos_q[i] <= staged_q[i];
                end
            end
            // Stopover copy only ever targets the first output area
            if (copy_take) begin
                out_pos_q[0] <= copy_src_low;
                out_pos_q[1] <= copy_src_high;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Refresh exchange; host_outputs_off is deliberately not read
    always_comb begin
        area_blank = '0;
        host_next = conv_word;
        for (int a = 0; a < AREA_COUNT; a++) begin
            area_blank[a] = zero_left_q[a] != 2'h0;
            if (area_blank[a]) begin
                host_next[a*WORD_BITS +: WORD_BITS] = '0;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            enable_q <= '0;
        end else if (unit_config_write) begin
            enable_q <= config_enable;
        end
    end

    // A count of two marks an area that has not seen its first refresh yet
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int a = 0; a < AREA_COUNT; a++) begin
                zero_left_q[a] <= '0;
            end
        end else begin
            for (int a = 0; a < AREA_COUNT; a++) begin
                if (unit_config_write && new_enable[a]) begin
                    zero_left_q[a] <= EXTRA_REFRESHES;
                end else if (area_refresh[a] && zero_left_q[a] == EXTRA_REFRESHES) begin
                    zero_left_q[a] <= first_left;
                end else if (area_refresh[a] && area_blank[a]) begin
                    zero_left_q[a] <= zero_left_q[a] - 2'h1;
                end
            end
        end
    end

    // Disabled areas simply hold their last values
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            host_out_q <= '0;
        end else begin
            for (int a = 0; a < AREA_COUNT; a++) begin
                if (area_refresh[a]) begin
                    host_out_q[a*WORD_BITS +: WORD_BITS] <= host_next[a*WORD_BITS +: WORD_BITS];
                end
            end
        end
    end

    // Input words are left alone while an area still sends zero
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            in_pos_q <= '0;
        end else begin
            for (int a = 0; a < AREA_COUNT; a++) begin
                if (area_refresh[a] && !area_blank[a]) begin
                    in_pos_q[2*a*POS_BITS +: 2*POS_BITS] <=
                        conv_pos[2*a*POS_BITS +: 2*POS_BITS];
                end
            end
        end
    end

    assign host_out_words = host_out_q;
    assign input_pos_words = in_pos_q;
    assign copy_armed = armed_q;
    assign copy_src_addr = src_q;
endmodule // wdlr_link

/* File: rtl/wdlr_pkg.sv */
// Constants for the word data link refresh block.
// Assumes a 40 MHz clock and a host that strobes each cyclic refresh.
// Functional notes
// - After enabling configuration write, first refresh sends zero, real data afterwards.
// - Under 10 ms between configuration write and first refresh adds one more zero refresh.
// - Words no longer enabled keep their last present values, never cleared.
// - Output word written during its refresh is delivered at the following refresh.
// - Refresh continues even while host load outputs are switched off.
// - Select value with leading digit one arms copy of two words at stopover; a stopover on a refresh edge copies nothing.
// - First position word gives low 8 bits, second gives high 8 bits.
// - Output digit zero gives bit 0, digits 1 to 9 give bit 1.
// - Input bit 0 gives digit 0, bit 1 gives digit 1.
package wdlr_pkg;
    localparam int AREA_COUNT = 4;
    localparam int DIGIT_COUNT = 8;
    localparam int DIGIT_BITS = 4;
    localparam int POS_BITS = DIGIT_COUNT * DIGIT_BITS;
    localparam int HALF_BITS = 8;
    localparam int WORD_BITS = 16;
    localparam int ADDR_BITS = 12;
    localparam int CLOCK_HZ = 40000000;
    localparam int SETTLE_MS = 10;
    localparam int SETTLE_CYCLES = (CLOCK_HZ / 1000) * SETTLE_MS;
    localparam logic [3:0] SEL_ARM_DIGIT = 4'h1;
    localparam logic [1:0] ZERO_REFRESHES = 2'h1;
    localparam logic [1:0] EXTRA_REFRESHES = 2'h2;
endpackage

/* File: rtl/wdlr_convert.sv */
// Digit to bit conversion for one link area.
// Assumes position words are packed BCD, digit 1 in the low nibble.
`timescale 1ns/1ps
module wdlr_convert
    import wdlr_pkg::*;
(
    // Position words of one output area
    input wire logic [POS_BITS-1:0] pos_low,
    input wire logic [POS_BITS-1:0] pos_high,
    // Host word data for that area
    input wire logic [WORD_BITS-1:0] host_word,
    output logic [WORD_BITS-1:0] out_word,
    output logic [POS_BITS-1:0] in_pos_low,
    output logic [POS_BITS-1:0] in_pos_high
);
    // Any nonzero digit counts as one; decimal points are not stored in digits
    function automatic logic [HALF_BITS-1:0] digits_to_bits(input logic [POS_BITS-1:0] p);
        logic [HALF_BITS-1:0] b;
        b = '0;
        for (int i = 0; i < DIGIT_COUNT; i++) begin
            b[i] = |p[i*DIGIT_BITS +: DIGIT_BITS];
        end
        return b;
    endfunction

    function automatic logic [POS_BITS-1:0] bits_to_digits(input logic [HALF_BITS-1:0] b);
        logic [POS_BITS-1:0] p;
        p = '0;
        for (int i = 0; i < DIGIT_COUNT; i++) begin
            p[i*DIGIT_BITS] = b[i];
        end
        return p;
    endfunction

    assign out_word = {digits_to_bits(pos_high), digits_to_bits(pos_low)};
    assign in_pos_low = bits_to_digits(host_word[HALF_BITS-1:0]);
    assign in_pos_high = bits_to_digits(host_word[WORD_BITS-1:HALF_BITS]);
endmodule // wdlr_convert

/* File: verification/wdlr_link_checker.sv */
// Assertions on the ports of the word data link block.
// Assumes one-cycle pulses and refreshes spaced several cycles apart.
`timescale 1ns/1ps
module wdlr_link_checker
    import wdlr_pkg::*;
#(parameter int SETTLE_COUNT = 20) (
    input wire logic clock, reset_n, refresh_strobe, unit_config_write, host_outputs_off,
    input wire logic stopover_select_write, stopover_output, copy_armed,
    input wire logic [AREA_COUNT-1:0] config_enable,
    input wire logic [AREA_COUNT*WORD_BITS-1:0] host_in_words, host_out_words,
    input wire logic [POS_BITS-1:0] stopover_copy_select,
    input wire logic [ADDR_BITS-1:0] copy_src_addr,
    input wire logic [AREA_COUNT*2*POS_BITS-1:0] input_pos_words
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // Refreshes seen since area 0 was last enabled, saturating at 3
    logic [AREA_COUNT-1:0] en_q;
    logic [1:0] rc_q;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            en_q <= '0;
            rc_q <= 2'h3;
        end else begin
            if (unit_config_write) en_q <= config_enable;
            if (unit_config_write && config_enable[0] && !en_q[0]) rc_q <= 2'h0;
            else if (refresh_strobe && rc_q != 2'h3) rc_q <= rc_q + 2'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_out_hold; $changed(host_out_words) |-> $past(refresh_strobe) || $past(refresh_strobe, 2); endproperty
    a_out_hold: assert property (p_out_hold) else $error("host words moved without refresh");
    property p_in_hold; $changed(input_pos_words) |-> $past(refresh_strobe) || $past(refresh_strobe, 2); endproperty
    a_in_hold: assert property (p_in_hold) else $error("input words moved without refresh");
    property p_arm_cause; $rose(copy_armed) |-> $past(stopover_select_write) && $past(stopover_copy_select[31:28]) == SEL_ARM_DIGIT; endproperty
    a_arm_cause: assert property (p_arm_cause) else $error("copy armed without select");
    property p_arm; stopover_select_write && stopover_copy_select[31:28] == SEL_ARM_DIGIT |=> copy_armed && copy_src_addr == $past(stopover_copy_select[11:0]); endproperty
    a_arm: assert property (p_arm) else $error("select did not arm copy");
    property p_disarm; stopover_select_write && stopover_copy_select == '0 |=> !copy_armed; endproperty
    a_disarm: assert property (p_disarm) else $error("zero select did not disarm");
    property p_zero_first; refresh_strobe && en_q[0] && rc_q == 2'h0 |-> ##2 host_out_words[15:0] == 16'h0; endproperty
    a_zero_first: assert property (p_zero_first) else $error("first refresh not zero");
    property p_off_hold; refresh_strobe && !en_q[3] |-> ##1 $stable(host_out_words[63:48]) ##1 $stable(host_out_words[63:48]); endproperty
    a_off_hold: assert property (p_off_hold) else $error("disabled area changed");
    property p_off_run; refresh_strobe && host_outputs_off && en_q[0] && rc_q == 2'h3 |-> ##2 input_pos_words[3:0] == {3'h0, $past(host_in_words[0], 2)}; endproperty
    a_off_run: assert property (p_off_run) else $error("refresh stopped with loads off");
    c_copy: cover property (stopover_output && copy_armed);
    c_zero: cover property (refresh_strobe && en_q[0] && rc_q == 2'h0);
    c_idle: cover property (refresh_strobe && !en_q[3]);
endmodule // wdlr_link_checker

/* File: verification/wdlr_host_model.sv */
// Host side model: refresh strobe on request, copy source words by address.
// Assumes the bench times each refresh request.
`timescale 1ns/1ps
module wdlr_host_model
    import wdlr_pkg::*;
(
    input wire logic refresh_req,
    output logic refresh_strobe,
    input wire logic [ADDR_BITS-1:0] copy_src_addr,
    output logic [POS_BITS-1:0] copy_src_low,
    output logic [POS_BITS-1:0] copy_src_high
);
    assign refresh_strobe = refresh_req;
    // Source words are fixed from time zero, long before any stopover
    assign copy_src_low = (copy_src_addr == 12'h234) ? 32'h10101010 : 32'h0;
    assign copy_src_high = (copy_src_addr == 12'h234) ? 32'h01010101 : 32'h0;
endmodule // wdlr_host_model

/* File: verification/wdlr_link_tb.sv */
// Self-checking bench for the word data link block.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ps
module wdlr_link_tb;
    import wdlr_pkg::*;
    logic clock = 1'b0, reset_n = 1'b0, host_outputs_off = 1'b0, copy_armed;
    logic [4:0] p = 5'h0;
    logic [3:0] config_enable = 4'h0;
    logic [2:0] write_index = 3'h0;
    logic [31:0] write_data = 32'h0, stopover_copy_select = 32'h0, copy_src_low, copy_src_high;
    logic [63:0] host_in_words = {4{16'h5a3c}}, host_out_words;
    logic [11:0] copy_src_addr;
    logic [255:0] input_pos_words;
    logic refresh_strobe;
    int fail_count = 0, tests_run = 0;
    wire refresh_req = p[0], unit_config_write = p[1], assign_value_command = p[2];
    wire stopover_select_write = p[3], stopover_output = p[4];
    wdlr_link #(.SETTLE_COUNT(20)) dut_u (.*);
    wdlr_host_model host_u (.*);
    always #12.5 clock = ~clock;
    function automatic logic [7:0] to_bits(logic [31:0] w);
        for (int i = 0; i < 8; i++) to_bits[i] = w[4*i+:4] != 4'h0;
    endfunction
    function automatic logic [31:0] to_digits(logic [7:0] b);
        for (int i = 0; i < 8; i++) to_digits[4*i+:4] = {3'h0, b[i]};
    endfunction
    wire [15:0] w_exp = {to_bits(32'h10), to_bits(32'h90801203)};
    ////////////////////////////////////////////////////////////////////////////////
    task automatic pulse(logic [4:0] m);
        p <= m;
        @(posedge clock);
        p <= 5'h0;
        repeat (3) @(posedge clock);
    endtask
    task automatic put(logic [2:0] i, logic [31:0] d);
        write_index <= i;
        write_data <= d;
        pulse(5'h04);
    endtask
    task automatic check(logic [63:0] got, logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("fail_count %0d tests_run %0d", fail_count, tests_run);
        if (fail_count == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_enable();
        for (int i = 0; i < 8; i++) put(i[2:0], i[0] ? 32'h10 : 32'h90801203);
        config_enable <= 4'h3;
        pulse(5'h02);
        repeat (30) @(posedge clock);
        pulse(5'h01);
        check(host_out_words, 64'h0);
        pulse(5'h01);
        check(host_out_words, {32'h0, w_exp, w_exp});
        check(input_pos_words[63:0], {to_digits(8'h5a), to_digits(8'h3c)});
        config_enable <= 4'hf;
        pulse(5'h02);
        pulse(5'h01);
        pulse(5'h01);
        check(host_out_words, {32'h0, w_exp, w_exp});
        pulse(5'h01);
        check(host_out_words, {4{w_exp}});
    endtask
    task automatic t_overlap();
        host_outputs_off <= 1'b1;
        host_in_words <= {4{16'h00ff}};
        write_index <= 3'h0;
        write_data <= 32'h1;
        pulse(5'h05);
        check(host_out_words[15:0], w_exp);
        check(input_pos_words[63:0], {32'h0, to_digits(8'hff)});
        pulse(5'h01);
        check(host_out_words[15:0], {to_bits(32'h10), 8'h01});
        host_outputs_off <= 1'b0;
    endtask
    task automatic t_copy();
        stopover_copy_select <= 32'h10000234;
        pulse(5'h08);
        check({copy_armed, copy_src_addr}, 13'h1234);
        pulse(5'h10);
        pulse(5'h01);
        check(host_out_words[15:0], 16'h55aa);
        stopover_copy_select <= 32'h0;
        pulse(5'h08);
        check(copy_armed, 1'b0);
        put(3'h0, 32'h1);
        pulse(5'h10);
        pulse(5'h01);
        check(host_out_words[15:0], 16'h5501);
    endtask
    task automatic t_hold();
        config_enable <= 4'h0;
        pulse(5'h02);
        put(3'h2, 32'h0);
        host_in_words <= 64'h0;
        pulse(5'h01);
        check(host_out_words, {w_exp, w_exp, w_exp, 16'h5501});
        check(input_pos_words[63:0], {32'h0, to_digits(8'hff)});
    endtask
    initial begin
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        t_enable();
        t_overlap();
        t_copy();
        t_hold();
        end_sim();
    end
    initial begin
        repeat (2000) @(posedge clock);
        fail_count++;
        end_sim();
    end
endmodule // wdlr_link_tb
bind wdlr_link wdlr_link_checker #(.SETTLE_COUNT(SETTLE_COUNT)) chk_u (.*);
